// ==== include/tpg_pkg.sv ====
// Purpose: Constants for the timer/pulse generator
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are local choices
package tpg_pkg;
    localparam logic [11:0] TPG_OFF_MODE = 12'h000;
    localparam logic [11:0] TPG_OFF_MODULO_HIGH_VALUE = 12'h004;
    localparam logic [11:0] TPG_OFF_MODULO_LOW_VALUE = 12'h008;
    localparam logic [11:0] TPG_OFF_STAT = 12'h00c;
    // Mode control bit positions
    localparam int TPG_B_MODE = 0;
    localparam int TPG_B_RUN = 1;
    localparam int TPG_B_RLD = 3;
    localparam int TPG_B_LAT = 4;
    localparam int TPG_B_STY = 5;
    localparam int TPG_B_DRV = 7;
    localparam logic [7:0] TPG_MODE_RST = 8'h00;
    localparam logic [7:0] TPG_MODULO_HIGH_VALUE_RST = 8'h00;
    localparam logic [7:0] TPG_MODULO_LOW_VALUE_RST = 8'h00;
    localparam logic [7:0] TPG_MODE_MASK = 8'hbb;
    // PWM periods as powers of two of fx
    localparam int TPG_BASIC_LOG2 = 10;
    localparam int TPG_SEC_LOG2 = 15;
    localparam int TPG_LATCH_W = 14;
    localparam logic [7:0] TPG_PRE_256 = 8'hff;
    localparam logic [7:0] TPG_PRE_128 = 8'h7f;
    localparam logic [7:0] TPG_PRE_64 = 8'h3f;
    localparam logic [7:0] TPG_PRE_32 = 8'h1f;
    localparam logic [7:0] TPG_PRE_16 = 8'h0f;
endpackage

// ==== src/tpg_top.sv ====
// Purpose: Timer/pulse generator with 8-bit timer and 14-bit PWM modes
// Assumes: pclk is fx; registers reached over APB, zero wait states
// Notes: Pulse pin is a two-signal tristate, enable active low
`timescale 1ns/1ps
module tpg_top (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pulse pin
    output logic pulse_pin_o,
    output logic pulse_pin_oe_n,
    // Event
    output logic generator_interrupt_signal
);
    import tpg_pkg::*;

    logic [7:0] mode_r, mode_nxt;
    logic [7:0] modulo_high_value_r, modulo_high_value_nxt;
    logic [7:0] modulo_low_value_r, modulo_low_value_nxt;
    logic [13:0] latch_r, latch_nxt;
    logic [13:0] act_r, act_nxt;
    logic [14:0] cnt_r, cnt_nxt;
    logic [7:0] pre_r, pre_nxt;
    logic [7:0] tcnt_r, tcnt_nxt;
    logic sq_r, sq_nxt;
    logic run_d_r, run_d_nxt;
    logic flag_r, flag_nxt;
    logic [31:0] prdata_nxt;
    logic pin_r, pin_nxt;
    logic oen_r, oen_nxt;
    logic irq_r, irq_nxt;
    logic wr, rd, tick, match, pwm_lo, evt;
    logic [7:0] pre_lim;
    logic [9:0] phase;
    logic [4:0] slot;
    logic [3:0] fine;

    wire mode_tmr = mode_r[TPG_B_MODE];
    wire run = mode_r[TPG_B_RUN];
    wire rld = mode_r[TPG_B_RLD];

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // Prescaler limit from one-hot code; an illegal code falls to fx/16
    always_comb begin
        case (modulo_low_value_r[6:2])
            5'b00001: pre_lim = TPG_PRE_256;
            5'b00010: pre_lim = TPG_PRE_128;
            5'b00100: pre_lim = TPG_PRE_64;
            5'b01000: pre_lim = TPG_PRE_32;
            default: pre_lim = TPG_PRE_16;
        endcase
    end

    assign tick = (pre_r == pre_lim);
    assign match = tick && (tcnt_r == modulo_high_value_r);

    // PWM: 10-bit phase within basic period, low 4 bits of the 5-bit slot select
    // which basic periods stretch by one cycle (spread low time)
    assign phase = cnt_r[9:0];
    assign slot = cnt_r[14:10];
    assign fine = {slot[0], slot[1], slot[2], slot[3]};
    always_comb begin
        pwm_lo = (phase < {2'b00, act_r[13:6]} * 10'd4
                  + {8'h00, act_r[5:4]}
                  + ((fine < act_r[3:0]) ? 10'd1 : 10'd0));
    end

    // Registers and bus
    always_comb begin
        mode_nxt = mode_r;
        modulo_high_value_nxt = modulo_high_value_r;
        modulo_low_value_nxt = modulo_low_value_r;
        prdata_nxt = prdata;
        if (wr) begin
            case (paddr)
                TPG_OFF_MODE: mode_nxt = pwdata[7:0] & TPG_MODE_MASK;
                TPG_OFF_MODULO_HIGH_VALUE: modulo_high_value_nxt = pwdata[7:0];
                TPG_OFF_MODULO_LOW_VALUE: modulo_low_value_nxt = pwdata[7:0];
                default: mode_nxt = mode_r;
            endcase
        end
        if (rd) begin
            case (paddr)
                TPG_OFF_MODE: prdata_nxt = {24'h0, mode_r};
                TPG_OFF_MODULO_HIGH_VALUE: prdata_nxt = {24'h0, modulo_high_value_r};
                TPG_OFF_MODULO_LOW_VALUE: prdata_nxt = {24'h0, modulo_low_value_r[7:2], 2'b00};
                TPG_OFF_STAT: prdata_nxt = {16'h0, sq_r, flag_r, latch_r[13:0]};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    // Counters, latch, flag
    always_comb begin
        latch_nxt = latch_r;
        act_nxt = act_r;
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        tcnt_nxt = tcnt_r;
        sq_nxt = sq_r;
        flag_nxt = flag_r;
        run_d_nxt = run;
        evt = 1'b0;
        if (rld)
            latch_nxt = {modulo_high_value_r, modulo_low_value_r[7:2]};
        if (!run) begin
            cnt_nxt = 15'h0;
            pre_nxt = 8'h00;
            tcnt_nxt = 8'h00;
        end else if (mode_tmr) begin
            if (!run_d_r) begin
                pre_nxt = 8'h00;
                tcnt_nxt = 8'h00;
            end else begin
                pre_nxt = tick ? 8'h00 : pre_r + 8'h01;
                if (match) begin
                    tcnt_nxt = 8'h00;
                    sq_nxt = !sq_r;
                    evt = 1'b1;
                end else if (tick) begin
                    tcnt_nxt = tcnt_r + 8'h01;
                end
            end
        end else begin
            cnt_nxt = cnt_r + 15'h1;
            if (&cnt_r)
                evt = 1'b1;
            if (&phase)
                act_nxt = latch_r;
        end
        // Event wins over software write-clear
        if (wr && paddr == TPG_OFF_STAT && pwdata[0])
            flag_nxt = 1'b0;
        if (evt)
            flag_nxt = 1'b1;
    end

    // Pin
    always_comb begin
        oen_nxt = !mode_r[TPG_B_DRV];
        if (!mode_r[TPG_B_STY])
            pin_nxt = mode_r[TPG_B_LAT];
        else if (mode_tmr)
            pin_nxt = sq_r;
        else
            pin_nxt = !(run && pwm_lo);
        irq_nxt = evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= TPG_MODE_RST;
            modulo_high_value_r <= TPG_MODULO_HIGH_VALUE_RST;
            modulo_low_value_r <= TPG_MODULO_LOW_VALUE_RST;
            latch_r <= 14'h0;
            act_r <= 14'h0;
            cnt_r <= 15'h0;
            pre_r <= 8'h00;
            tcnt_r <= 8'h00;
            sq_r <= 1'b0;
            run_d_r <= 1'b0;
            flag_r <= 1'b0;
            prdata <= 32'h0;
            pin_r <= 1'b0;
            oen_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            modulo_high_value_r <= modulo_high_value_nxt;
            modulo_low_value_r <= modulo_low_value_nxt;
            latch_r <= latch_nxt;
            act_r <= act_nxt;
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
            tcnt_r <= tcnt_nxt;
            sq_r <= sq_nxt;
            run_d_r <= run_d_nxt;
            flag_r <= flag_nxt;
            prdata <= prdata_nxt;
            pin_r <= pin_nxt;
            oen_r <= oen_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign pulse_pin_o = pin_r;
    assign pulse_pin_oe_n = oen_r;
    assign generator_interrupt_signal = irq_r;

    // Checks
    property p_float;
        @(posedge pclk) disable iff (!presetn)
        !mode_r[TPG_B_DRV] |=> pulse_pin_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("pin not floated");
    property p_static;
        @(posedge pclk) disable iff (!presetn)
        !mode_r[TPG_B_STY] |=> pulse_pin_o == $past(mode_r[TPG_B_LAT]);
    endproperty
    a_static: assert property (p_static) else $error("static level");
    property p_pwm_evt;
        @(posedge pclk) disable iff (!presetn)
        (run && !mode_tmr && &cnt_r) |=> flag_r && generator_interrupt_signal;
    endproperty
    a_pwm_evt: assert property (p_pwm_evt) else $error("pwm irq");
    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        !run |=> cnt_r == 15'h0 && tcnt_r == 8'h00;
    endproperty
    a_stop: assert property (p_stop) else $error("not stopped");
    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        !rld |=> latch_r == $past(latch_r);
    endproperty
    a_reload: assert property (p_reload) else $error("reload leak");
    property p_match;
        @(posedge pclk) disable iff (!presetn)
        (run && run_d_r && mode_tmr && match) |=> sq_r != $past(sq_r)
            && tcnt_r == 8'h00;
    endproperty
    a_match: assert property (p_match) else $error("match");
    property p_act;
        @(posedge pclk) disable iff (!presetn)
        (run && !mode_tmr && !(&phase)) |=> act_r == $past(act_r);
    endproperty
    a_act: assert property (p_act) else $error("mid-period update");
    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (mode_tmr && run && !run_d_r) |=> pre_r == 8'h00 && tcnt_r == 8'h00;
    endproperty
    a_start: assert property (p_start) else $error("start");
    property p_flag;
        @(posedge pclk) disable iff (!presetn)
        evt |=> flag_r;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    // Shortest interval is 16 cycles, so the pulse never runs on
    property p_irq_pulse;
        @(posedge pclk) disable iff (!presetn)
        generator_interrupt_signal |=> !generator_interrupt_signal;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq width");
    property p_prescale;
        @(posedge pclk) disable iff (!presetn)
        (run && run_d_r && mode_tmr && tick) |=> pre_r == 8'h00;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale");
    property p_modulo_low_value_rd;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == TPG_OFF_MODULO_LOW_VALUE) |=> prdata[1:0] == 2'b00;
    endproperty
    a_modulo_low_value_rd: assert property (p_modulo_low_value_rd) else $error("modulo_low_value low bits");
    property p_pwm_idle;
        @(posedge pclk) disable iff (!presetn)
        (mode_r[TPG_B_STY] && !mode_tmr && !run) |=> pulse_pin_o;
    endproperty
    a_pwm_idle: assert property (p_pwm_idle) else $error("pwm idle");
    property p_square;
        @(posedge pclk) disable iff (!presetn)
        (mode_r[TPG_B_STY] && mode_tmr) |=> pulse_pin_o == $past(sq_r);
    endproperty
    a_square: assert property (p_square) else $error("square out");
endmodule

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the timer/pulse generator
// Assumes: Zero wait APB, pin load model on the pulse pin
// Notes: One PWM value only, secondary periods are long
`timescale 1ns/1ps
module testbench;
    import tpg_pkg::*;
    logic pclk, psel, penable, pwrite, pready, pslverr, pin_o, pin_oe_n, irq;
    logic presetn = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, low_cnt, rd, c;
    logic p;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    tpg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_pin_o(pin_o),
        .pulse_pin_oe_n(pin_oe_n), .generator_interrupt_signal(irq));
    tpg_load LOAD (.pclk(pclk), .presetn(presetn), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .low_cnt(low_cnt));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait for the next interrupt pulse, n holds the gap
    task automatic gap();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (irq !== 1'b1 && n < 70000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_regs();
        apb(1'b0, TPG_OFF_MODE, 32'h0);
        chk(rd, {24'h0, TPG_MODE_RST});
        apb(1'b0, TPG_OFF_MODULO_HIGH_VALUE, 32'h0);
        chk(rd, {24'h0, TPG_MODULO_HIGH_VALUE_RST});
        apb(1'b0, TPG_OFF_MODULO_LOW_VALUE, 32'h0);
        chk(rd[7:2], TPG_MODULO_LOW_VALUE_RST[7:2]);
        apb(1'b1, TPG_OFF_MODE, 32'hff);
        apb(1'b0, TPG_OFF_MODE, 32'h0);
        chk(rd, 32'hbb);
        apb(1'b1, TPG_OFF_MODULO_LOW_VALUE, 32'h7c);
        apb(1'b0, TPG_OFF_MODULO_LOW_VALUE, 32'h0);
        chk(rd[7:2], 6'h1f);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_static();
        apb(1'b1, TPG_OFF_MODE, 32'h90);
        repeat (2) @(posedge pclk);
        chk({pin_oe_n, pin_o}, 2'b01);
        apb(1'b1, TPG_OFF_MODE, 32'h80);
        repeat (2) @(posedge pclk);
        chk({pin_oe_n, pin_o}, 2'b00);
        apb(1'b1, TPG_OFF_MODE, 32'h30);
        repeat (2) @(posedge pclk);
        chk(pin_oe_n, 1'b1);
        $display("test static done");
    endtask
    task automatic t_timer();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, TPG_OFF_MODE, 32'ha9);
            apb(1'b1, TPG_OFF_STAT, 32'h1);
            apb(1'b1, TPG_OFF_MODULO_LOW_VALUE, 32'h04 << i);
            apb(1'b1, TPG_OFF_MODULO_HIGH_VALUE, i % 2 + 1);
            apb(1'b1, TPG_OFF_MODE, 32'hab);
            gap();
            gap();
            chk(n, (256 >> i) * (i % 2 + 2));
            @(posedge pclk);
            p = pin_o;
            gap();
            @(posedge pclk);
            chk(pin_o, {31'h0, ~p});
            apb(1'b0, TPG_OFF_STAT, 32'h0);
            chk(rd[14], 1'b1);
        end
        apb(1'b1, TPG_OFF_MODE, 32'ha9);
        apb(1'b1, TPG_OFF_STAT, 32'h1);
        repeat (4) @(posedge pclk);
        n = 0;
        repeat (600) begin
            @(posedge pclk);
            if (irq === 1'b1) n++;
        end
        chk(n, 0);
        apb(1'b0, TPG_OFF_STAT, 32'h0);
        chk(rd[14], 1'b0);
        $display("test timer done");
    endtask
    task automatic t_pwm();
        apb(1'b1, TPG_OFF_MODULO_HIGH_VALUE, 32'h1);
        apb(1'b1, TPG_OFF_MODULO_LOW_VALUE, 32'h0);
        apb(1'b1, TPG_OFF_MODE, 32'haa);
        gap();
        c = low_cnt;
        gap();
        chk(n, 1 << TPG_SEC_LOG2);
        chk(low_cnt - c, 32'd128);
        apb(1'b1, TPG_OFF_MODE, 32'ha2);
        apb(1'b1, TPG_OFF_MODULO_HIGH_VALUE, 32'hff);
        apb(1'b1, TPG_OFF_MODULO_LOW_VALUE, 32'hfc);
        apb(1'b0, TPG_OFF_STAT, 32'h0);
        chk(rd[13:0], 14'h0040);
        apb(1'b1, TPG_OFF_MODE, 32'haa);
        apb(1'b0, TPG_OFF_STAT, 32'h0);
        chk(rd[13:0], 14'h3fff);
        $display("test pwm done");
    endtask
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_static();
        t_timer();
        t_pwm();
        summarize();
    end
    // Tests need about 70k cycles
    initial begin
        #2400000;
        mismatches++;
        summarize();
    end
endmodule

// ==== verif/tpg_load.sv ====
// Purpose: Load on the pulse pin, counts driven low cycles
// Assumes: One cycle of pclk is one fx period
// Notes: Undriven cycles are not counted, no pull on the pin
`timescale 1ns/1ps
module tpg_load (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin
    input wire logic pin_o,
    input wire logic pin_oe_n,
    // Observation
    output logic [31:0] low_cnt
);
    // Filter sees only the driven low time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 32'h0;
        end else if (!pin_oe_n && !pin_o) begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
endmodule
